// ==== src/rsf_framer.sv ====
// half-duplex serial port: register port, bit engines, framing and both buffers
`timescale 1ns/1ps
module rsf_framer (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire rsf_pkg::rsf_bus_req_t bus,
	output logic [31:0]                rdata,
	input  wire logic                  line_in,
	output logic                       line_out,
	output logic                       line_oe_n,
	output logic                       rts
);
	logic [31:0]               ctrl;
	logic [15:0]               div_reg;
	logic [15:0]               tmo_reg;
	rsf_pkg::rsf_ids_t         ids;
	rsf_pkg::rsf_mode_t        mode;
	rsf_pkg::rsf_tx_state_t    tstate;
	rsf_pkg::rsf_tx_state_t    next_tstate;
	rsf_pkg::rsf_rx_state_t    rstate;
	rsf_pkg::rsf_rx_state_t    next_rstate;
	rsf_pkg::rsf_rx_state_t    home;
	logic [1:0]                width;
	logic [3:0]                nbits;
	logic [7:0]                wmask;
	logic [15:0]               div_eff;
	logic [15:0]               baud_cnt;
	logic [15:0]               tmo_cnt;
	logic [15:0]               tx_tick;
	logic [15:0]               rx_tick;
	logic [3:0]                tx_bits;
	logic [3:0]                rx_bits;
	logic [9:0]                tx_shift;
	logic [7:0]                tx_byte;
	logic [7:0]                rx_sh;
	logic [7:0]                rx_data;
	logic [rsf_pkg::CNT_W-1:0] pay_left;
	logic [rsf_pkg::CNT_W-1:0] txf_count;
	logic [rsf_pkg::CNT_W-1:0] rxf_count;
	logic [7:0]                txf_data;
	logic [7:0]                rxf_data;
	logic [31:0]               send_status_value;
	logic                      point_to_point_mode;
	logic                      framed;
	logic                      acked;
	logic                      s0v;
	logic                      s1v;
	logic                      e0v;
	logic                      e1v;
	logic                      sync1;
	logic                      sync2;
	logic                      baud_tick;
	logic                      tmo_run;
	logic                      tmo_exp;
	logic                      tx_busy;
	logic                      tx_go;
	logic                      tx_pop;
	logic                      line_free;
	logic                      rx_busy;
	logic                      rx_last;
	logic                      rx_byte_v;
	logic                      rx_stop_err;
	logic                      rx_pend;
	logic                      rx_push;
	logic                      rx_commit;
	logic                      rx_abort;
	logic                      rx_done;
	logic                      txf_valid;
	logic                      txf_ready;
	logic                      rxf_valid;
	logic                      rxf_ready;
	logic                      serial_configure_request;
	logic                      serial_send_request;
	logic                      serial_receive_request;
	logic                      send_ok;
	logic                      st_wr;
	logic                      tmo_flag;
	logic                      char_err;
	logic                      frame_err;
	logic                      overrun;
	logic                      ack_ok;
	logic                      ack_tmo;
	logic                      char_err_set;
	logic                      frame_err_set;
	logic                      ack_ok_set;
	logic                      ack_tmo_set;

	// identifiers outside 01h..1Fh (FFh included) count as absent
	function automatic logic id_ok(input logic [7:0] v);
		id_ok = (v >= rsf_pkg::ID_MIN) && (v <= rsf_pkg::ID_MAX);
	endfunction

	assign mode    = rsf_pkg::rsf_mode_t'(ctrl[rsf_pkg::CTRL_MODE_LSB +: 3]);
	assign width   = ctrl[rsf_pkg::CTRL_WIDTH_LSB +: 2];
	assign point_to_point_mode     = ctrl[rsf_pkg::CTRL_PTP_BIT];
	assign nbits   = rsf_pkg::NBITS_MIN + {2'b00, width};
	assign wmask   = rsf_pkg::FULL_MASK >> (2'd3 - width);
	assign framed  = mode == rsf_pkg::MODE_FRAMED;
	assign acked   = (mode == rsf_pkg::MODE_3964R) || (mode == rsf_pkg::MODE_USS) ||
	                 (mode == rsf_pkg::MODE_MODBUS);
	assign s0v     = framed && id_ok(ids.start0);
	assign s1v     = framed && id_ok(ids.start1);
	assign e0v     = framed && id_ok(ids.end0);
	assign e1v     = framed && id_ok(ids.end1);
	assign home    = s0v ? rsf_pkg::R_S0 : (s1v ? rsf_pkg::R_S1 : rsf_pkg::R_PAY);
	assign div_eff = (div_reg < rsf_pkg::MIN_DIV) ? rsf_pkg::MIN_DIV : div_reg;

	// register port
	assign serial_configure_request = bus.we && ((bus.addr == rsf_pkg::ADDR_CTRL) ||
	                                  (bus.addr == rsf_pkg::ADDR_DIV) || (bus.addr == rsf_pkg::ADDR_IDS) ||
	                                  (bus.addr == rsf_pkg::ADDR_TMO));
	assign serial_send_request      = bus.we && (bus.addr == rsf_pkg::ADDR_CMD) && bus.wdata[rsf_pkg::CMD_SEND];
	assign serial_receive_request   = bus.re && (bus.addr == rsf_pkg::ADDR_RXDATA);
	assign st_wr                    = bus.we && (bus.addr == rsf_pkg::ADDR_STATUS);

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl    <= rsf_pkg::CTRL_RST;
			div_reg <= rsf_pkg::DIV_RST;
			ids     <= rsf_pkg::IDS_RST;
			tmo_reg <= rsf_pkg::TMO_RST;
		end else if (bus.we) begin
			case (bus.addr)
				rsf_pkg::ADDR_CTRL: ctrl <= bus.wdata;
				rsf_pkg::ADDR_DIV:  div_reg <= bus.wdata[15:0];
				rsf_pkg::ADDR_IDS:  ids <= bus.wdata;
				rsf_pkg::ADDR_TMO:  tmo_reg <= bus.wdata[15:0];
				default: ;
			endcase
		end
	end

	assign send_status_value = {22'h0, !txf_ready, ack_tmo, ack_ok, tstate == rsf_pkg::T_ACK,
	                            overrun, frame_err, char_err, tmo_flag, rxf_valid, tstate != rsf_pkg::T_IDLE};

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata <= '0;
		end else if (bus.re) begin
			case (bus.addr)
				rsf_pkg::ADDR_CTRL:   rdata <= ctrl;
				rsf_pkg::ADDR_DIV:    rdata <= {16'h0, div_reg};
				rsf_pkg::ADDR_IDS:    rdata <= ids;
				rsf_pkg::ADDR_TMO:    rdata <= {16'h0, tmo_reg};
				rsf_pkg::ADDR_RXDATA: rdata <= {23'h0, rxf_valid, rxf_data};
				rsf_pkg::ADDR_STATUS: rdata <= send_status_value;
				rsf_pkg::ADDR_COUNT:  rdata <= {4'h0, rxf_count, 4'h0, txf_count};
				default:              rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end

	// sticky status, set beats clear
	always_ff @(posedge clk) begin
		if (srst) begin
			tmo_flag  <= 1'b0;
			char_err  <= 1'b0;
			frame_err <= 1'b0;
			overrun   <= 1'b0;
			ack_ok    <= 1'b0;
			ack_tmo   <= 1'b0;
		end else begin
			tmo_flag  <= (tmo_flag & ~(st_wr & bus.wdata[rsf_pkg::ST_TMO])) | (tmo_exp & rx_pend);
			char_err  <= (char_err & ~(st_wr & bus.wdata[rsf_pkg::ST_CHAR_ERR])) | char_err_set;
			frame_err <= (frame_err & ~(st_wr & bus.wdata[rsf_pkg::ST_FRAME_ERR])) | frame_err_set;
			overrun   <= (overrun & ~(st_wr & bus.wdata[rsf_pkg::ST_OVERRUN])) | (rx_push & ~rxf_ready);
			ack_ok    <= (ack_ok & ~((st_wr & bus.wdata[rsf_pkg::ST_ACK_OK]) | send_ok)) | ack_ok_set;
			ack_tmo   <= (ack_tmo & ~((st_wr & bus.wdata[rsf_pkg::ST_ACK_TMO]) | send_ok)) | ack_tmo_set;
		end
	end

	// buffers
	rsf_fifo u_txf (
		.clk      (clk),
		.srst     (srst),
		.flush    (bus.we && (bus.addr == rsf_pkg::ADDR_CMD) && bus.wdata[rsf_pkg::CMD_TX_FLUSH]),
		.wr_valid (bus.we && (bus.addr == rsf_pkg::ADDR_TXDATA)),
		.wr_ready (txf_ready),
		.wr_data  (bus.wdata[7:0]),
		.commit   (1'b1),
		.abort    (1'b0),
		.rd_valid (txf_valid),
		.rd_ready (tx_pop),
		.rd_data  (txf_data),
		.count    (txf_count)
	);

	rsf_fifo u_rxf (
		.clk      (clk),
		.srst     (srst),
		.flush    (bus.we && (bus.addr == rsf_pkg::ADDR_CMD) && bus.wdata[rsf_pkg::CMD_RX_FLUSH]),
		.wr_valid (rx_push),
		.wr_ready (rxf_ready),
		.wr_data  (rx_data),
		.commit   (rx_commit),
		.abort    (rx_abort),
		.rd_valid (rxf_valid),
		.rd_ready (serial_receive_request),
		.rd_data  (rxf_data),
		.count    (rxf_count)
	);

	// line input synchroniser
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
		end else begin
			sync1 <= line_in;
			sync2 <= sync1;
		end
	end

	// free bit-time tick for the character timeout
	assign baud_tick = baud_cnt >= div_eff - 16'd1;

	always_ff @(posedge clk) begin
		if (srst || baud_tick)
			baud_cnt <= '0;
		else
			baud_cnt <= baud_cnt + 16'd1;
	end

	assign tmo_run = rx_pend || ((tstate == rsf_pkg::T_ACK) && !tx_busy);
	assign tmo_exp = tmo_run && baud_tick && ((tmo_cnt + 16'd1) >= tmo_reg);

	always_ff @(posedge clk) begin
		if (srst || rx_byte_v || !tmo_run || tmo_exp)
			tmo_cnt <= '0;
		else if (baud_tick)
			tmo_cnt <= tmo_cnt + 16'd1;
	end

	always_ff @(posedge clk) begin
		if (srst || rx_done || tmo_exp)
			rx_pend <= 1'b0;
		else if (rx_byte_v)
			rx_pend <= 1'b1;
	end

	// transmit bit engine; driver on only while shifting
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_busy  <= 1'b0;
			tx_shift <= '1;
			tx_bits  <= '0;
			tx_tick  <= '0;
		end else if (!tx_busy) begin
			if (tx_go) begin
				tx_busy  <= 1'b1;
				tx_shift <= {1'b1, tx_byte | ~wmask, 1'b0};
				tx_bits  <= nbits + rsf_pkg::FRAME_EXTRA;
				tx_tick  <= div_eff - 16'd1;
			end
		end else if (tx_tick == 16'd0) begin
			tx_tick  <= div_eff - 16'd1;
			tx_shift <= {1'b1, tx_shift[9:1]};
			tx_bits  <= tx_bits - 4'd1;
			if (tx_bits == 4'd1)
				tx_busy <= 1'b0;
		end else begin
			tx_tick <= tx_tick - 16'd1;
		end
	end

	assign line_out  = tx_shift[0];
	assign line_oe_n = !tx_busy;
	assign rts       = tx_busy;

	// receive bit engine, deaf while we drive the pair
	always_ff @(posedge clk) begin
		if (srst) begin
			rx_busy <= 1'b0;
			rx_tick <= '0;
			rx_bits <= '0;
			rx_sh   <= '0;
		end else if (!rx_busy) begin
			if (point_to_point_mode && !tx_busy && !sync2) begin
				rx_busy <= 1'b1;
				rx_tick <= div_eff >> 1;
				rx_bits <= nbits + rsf_pkg::FRAME_EXTRA;
			end
		end else if (rx_tick != 16'd0) begin
			rx_tick <= rx_tick - 16'd1;
		end else begin
			rx_tick <= div_eff - 16'd1;
			rx_bits <= rx_bits - 4'd1;
			if (rx_bits == nbits + rsf_pkg::FRAME_EXTRA) begin
				if (sync2)
					rx_busy <= 1'b0;
			end else if (rx_bits == 4'd1) begin
				rx_busy <= 1'b0;
			end else begin
				rx_sh <= {sync2, rx_sh[7:1]};
			end
		end
	end

	assign rx_last     = rx_busy && (rx_tick == 16'd0) && (rx_bits == 4'd1);
	assign rx_byte_v   = rx_last && sync2;
	assign rx_stop_err = rx_last && !sync2;
	assign rx_data     = rx_sh >> (4'd8 - nbits);

	// receive framing
	always_comb begin
		next_rstate   = rstate;
		rx_push       = 1'b0;
		rx_commit     = 1'b0;
		rx_abort      = 1'b0;
		rx_done       = 1'b0;
		char_err_set  = 1'b0;
		frame_err_set = rx_stop_err;
		if (serial_configure_request) begin
			rx_abort    = 1'b1;
			rx_done     = 1'b1;
			// restart at top, home is rechecked on the new ids next cycle
			next_rstate = rsf_pkg::R_S0;
		end else if (tmo_exp && rx_pend && framed) begin
			if (!e0v && !e1v)
				rx_commit = 1'b1;
			else
				rx_abort = 1'b1;
			rx_done     = 1'b1;
			next_rstate = home;
		end else if (rx_byte_v && !framed) begin
			rx_push   = 1'b1;
			rx_commit = 1'b1;
		end else if (rx_byte_v) begin
			case (rstate)
				rsf_pkg::R_S0: begin
					if (rx_data == ids.start0)
						next_rstate = s1v ? rsf_pkg::R_S1 : rsf_pkg::R_PAY;
				end
				rsf_pkg::R_S1: begin
					if (rx_data == ids.start1) begin
						next_rstate = rsf_pkg::R_PAY;
					end else begin
						frame_err_set = 1'b1;
						next_rstate   = home;
					end
				end
				rsf_pkg::R_PAY: begin
					if (e0v && (rx_data == ids.end0)) begin
						if (e1v) begin
							next_rstate = rsf_pkg::R_E1;
						end else begin
							rx_commit   = 1'b1;
							rx_done     = 1'b1;
							next_rstate = home;
						end
					end else if (!e0v && e1v && (rx_data == ids.end1)) begin
						rx_commit   = 1'b1;
						rx_done     = 1'b1;
						next_rstate = home;
					end else begin
						rx_push      = 1'b1;
						char_err_set = (rx_data < rsf_pkg::PAYLOAD_MIN) || (rx_data > wmask);
					end
				end
				rsf_pkg::R_E1: begin
					if (rx_data == ids.end1) begin
						rx_commit = 1'b1;
					end else begin
						rx_abort      = 1'b1;
						frame_err_set = 1'b1;
					end
					rx_done     = 1'b1;
					next_rstate = home;
				end
				default: next_rstate = home;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			rstate <= rsf_pkg::R_S0;
		else if (rx_done)
			rstate <= next_rstate;
		else if (rstate == rsf_pkg::R_S0 && !s0v)
			rstate <= home;
		else
			rstate <= next_rstate;
	end

	// transmit framing and acknowledgement wait
	assign line_free = point_to_point_mode && !tx_busy && !rx_busy;

	always_comb begin
		next_tstate = tstate;
		tx_go       = 1'b0;
		tx_pop      = 1'b0;
		tx_byte     = txf_data;
		send_ok     = 1'b0;
		ack_ok_set  = 1'b0;
		ack_tmo_set = 1'b0;
		case (tstate)
			rsf_pkg::T_IDLE: begin
				if (!framed && !acked) begin
					if (txf_valid && line_free) begin
						tx_go  = 1'b1;
						tx_pop = 1'b1;
					end
				end else if (serial_send_request) begin
					send_ok     = 1'b1;
					next_tstate = rsf_pkg::T_S0;
				end
			end
			rsf_pkg::T_S0: begin
				if (!s0v) begin
					next_tstate = rsf_pkg::T_S1;
				end else if (line_free) begin
					tx_go       = 1'b1;
					tx_byte     = ids.start0;
					next_tstate = rsf_pkg::T_S1;
				end
			end
			rsf_pkg::T_S1: begin
				if (!s1v) begin
					next_tstate = rsf_pkg::T_PAY;
				end else if (line_free) begin
					tx_go       = 1'b1;
					tx_byte     = ids.start1;
					next_tstate = rsf_pkg::T_PAY;
				end
			end
			rsf_pkg::T_PAY: begin
				if (pay_left == '0) begin
					next_tstate = rsf_pkg::T_E0;
				end else if (line_free && txf_valid) begin
					tx_go  = 1'b1;
					tx_pop = 1'b1;
				end
			end
			rsf_pkg::T_E0: begin
				if (!e0v) begin
					next_tstate = rsf_pkg::T_E1;
				end else if (line_free) begin
					tx_go       = 1'b1;
					tx_byte     = ids.end0;
					next_tstate = rsf_pkg::T_E1;
				end
			end
			rsf_pkg::T_E1: begin
				if (!e1v) begin
					next_tstate = acked ? rsf_pkg::T_ACK : rsf_pkg::T_IDLE;
				end else if (line_free) begin
					tx_go       = 1'b1;
					tx_byte     = ids.end1;
					next_tstate = rsf_pkg::T_IDLE;
				end
			end
			rsf_pkg::T_ACK: begin
				if (rx_byte_v) begin
					ack_ok_set  = 1'b1;
					next_tstate = rsf_pkg::T_IDLE;
				end else if (tmo_exp) begin
					ack_tmo_set = 1'b1;
					next_tstate = rsf_pkg::T_IDLE;
				end
			end
			default: next_tstate = rsf_pkg::T_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst || (bus.we && (bus.addr == rsf_pkg::ADDR_CTRL)))
			tstate <= rsf_pkg::T_IDLE;
		else
			tstate <= next_tstate;
	end

	always_ff @(posedge clk) begin
		if (srst || (bus.we && (bus.addr == rsf_pkg::ADDR_CMD) && bus.wdata[rsf_pkg::CMD_TX_FLUSH]))
			pay_left <= '0;
		else if (send_ok)
			pay_left <= txf_count;
		else if (tx_pop && (tstate == rsf_pkg::T_PAY))
			pay_left <= pay_left - rsf_pkg::CNT_W'(1);
	end
endmodule

// ==== inc/rsf_pkg.sv ====
// constants, register map, states and carrier types of the serial framer
package rsf_pkg;
	localparam int unsigned CLK_HZ     = 10_000_000;
	localparam int unsigned MAX_BAUD   = 115_200;
	localparam logic [15:0] MIN_DIV    = 16'((CLK_HZ + MAX_BAUD - 1) / MAX_BAUD);
	localparam int unsigned BANK_BYTES = 1024;
	localparam int unsigned FIFO_DEPTH = 2 * BANK_BYTES;
	localparam int unsigned PTR_W      = $clog2(FIFO_DEPTH);
	localparam int unsigned CNT_W      = PTR_W + 1;

	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_DIV    = 8'h04;
	localparam logic [7:0] ADDR_IDS    = 8'h08;
	localparam logic [7:0] ADDR_TMO    = 8'h0c;
	localparam logic [7:0] ADDR_TXDATA = 8'h10;
	localparam logic [7:0] ADDR_RXDATA = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_CMD    = 8'h1c;
	localparam logic [7:0] ADDR_COUNT  = 8'h20;

	localparam int unsigned CTRL_MODE_LSB  = 0;
	localparam int unsigned CTRL_WIDTH_LSB = 4;
	localparam int unsigned CTRL_PTP_BIT   = 8;
	localparam int unsigned COUNT_RX_LSB   = 16;
	localparam int unsigned RXDATA_VALID   = 8;

	localparam logic [31:0] CTRL_RST = 32'h0000_0130;
	localparam logic [31:0] IDS_RST  = 32'hffff_ffff;
	localparam logic [15:0] DIV_RST  = MIN_DIV;
	localparam logic [15:0] TMO_RST  = 16'h0020;

	localparam logic [7:0] ID_MIN      = 8'h01;
	localparam logic [7:0] ID_MAX      = 8'h1f;
	localparam logic [7:0] PAYLOAD_MIN = 8'h20;
	localparam logic [7:0] FULL_MASK   = 8'hff;
	localparam logic [3:0] NBITS_MIN   = 4'h5;
	localparam logic [3:0] FRAME_EXTRA = 4'h2;

	localparam int unsigned ST_TX_BUSY   = 0;
	localparam int unsigned ST_RX_AVAIL  = 1;
	localparam int unsigned ST_TMO       = 2;
	localparam int unsigned ST_CHAR_ERR  = 3;
	localparam int unsigned ST_FRAME_ERR = 4;
	localparam int unsigned ST_OVERRUN   = 5;
	localparam int unsigned ST_ACK_WAIT  = 6;
	localparam int unsigned ST_ACK_OK    = 7;
	localparam int unsigned ST_ACK_TMO   = 8;
	localparam int unsigned ST_TX_FULL   = 9;

	localparam int unsigned CMD_SEND     = 0;
	localparam int unsigned CMD_RX_FLUSH = 1;
	localparam int unsigned CMD_TX_FLUSH = 2;

	typedef enum logic [2:0] {
		MODE_ASCII  = 3'h0,
		MODE_FRAMED = 3'h1,
		MODE_3964R  = 3'h2,
		MODE_USS    = 3'h3,
		MODE_MODBUS = 3'h4
	} rsf_mode_t;

	typedef enum logic [2:0] {
		T_IDLE = 3'b000,
		T_S0   = 3'b001,
		T_S1   = 3'b011,
		T_PAY  = 3'b010,
		T_E0   = 3'b110,
		T_E1   = 3'b111,
		T_ACK  = 3'b101
	} rsf_tx_state_t;

	typedef enum logic [1:0] {
		R_S0  = 2'b00,
		R_S1  = 2'b01,
		R_PAY = 2'b11,
		R_E1  = 2'b10
	} rsf_rx_state_t;

	typedef struct packed {
		logic [7:0] end1;
		logic [7:0] end0;
		logic [7:0] start1;
		logic [7:0] start0;
	} rsf_ids_t;

	typedef struct packed {
		logic        we;
		logic        re;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} rsf_bus_req_t;
endpackage

// ==== src/rsf_fifo.sv ====
// byte fifo of two banks with a commit point that hides unfinished frames
`timescale 1ns/1ps
module rsf_fifo (
	input  wire logic                      clk,
	input  wire logic                      srst,
	input  wire logic                      flush,
	input  wire logic                      wr_valid,
	output logic                           wr_ready,
	input  wire logic [7:0]                wr_data,
	input  wire logic                      commit,
	input  wire logic                      abort,
	output logic                           rd_valid,
	input  wire logic                      rd_ready,
	output logic [7:0]                     rd_data,
	output logic [rsf_pkg::CNT_W-1:0]      count
);
	logic [7:0]                mem [rsf_pkg::FIFO_DEPTH];
	logic [rsf_pkg::CNT_W-1:0] wr_ptr;
	logic [rsf_pkg::CNT_W-1:0] cm_ptr;
	logic [rsf_pkg::CNT_W-1:0] rd_ptr;
	logic                      push;
	logic                      pop;

	assign wr_ready = (wr_ptr - rd_ptr) != rsf_pkg::CNT_W'(rsf_pkg::FIFO_DEPTH);
	assign push     = wr_valid && wr_ready && !abort;
	assign rd_valid = cm_ptr != rd_ptr;
	assign pop      = rd_valid && rd_ready;
	assign rd_data  = mem[rd_ptr[rsf_pkg::PTR_W-1:0]];
	assign count    = cm_ptr - rd_ptr;

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr[rsf_pkg::PTR_W-1:0]] <= wr_data;
	end

	always_ff @(posedge clk) begin
		if (srst || flush) begin
			wr_ptr <= '0;
			cm_ptr <= '0;
		end else if (abort) begin
			wr_ptr <= cm_ptr;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + rsf_pkg::CNT_W'(1);
			if (commit)
				cm_ptr <= wr_ptr + rsf_pkg::CNT_W'(push);
		end
	end

	always_ff @(posedge clk) begin
		if (srst || flush)
			rd_ptr <= '0;
		else if (pop)
			rd_ptr <= rd_ptr + rsf_pkg::CNT_W'(1);
	end
endmodule

// ==== tb/rsf_framer_asserts.sv ====
// port-level assertions for the serial framer
`timescale 1ns/1ps
module rsf_framer_asserts (
	input wire logic                  clk,
	input wire logic                  srst,
	input wire rsf_pkg::rsf_bus_req_t bus,
	input wire logic [31:0]           rdata,
	input wire logic                  line_in,
	input wire logic                  line_out,
	input wire logic                  line_oe_n,
	input wire logic                  rts
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	rts_tracks_oe_a: assert property (rts == !line_oe_n)
		else $error("rts differs from driver enable");
	idle_high_a: assert property (line_oe_n |-> line_out)
		else $error("line not idle high while released");
	stop_before_release_a: assert property ($rose(line_oe_n) |-> $past(line_out))
		else $error("driver released before stop bit");
	start_bit_a: assert property ($fell(line_oe_n) |-> !line_out [*8])
		else $error("frame does not open with a start bit");
	rdata_pulse_a: assert property (!bus.re |=> rdata == 32'h0)
		else $error("read data present without read");
	reset_quiet_a: assert property ($past(srst) |-> line_oe_n && rdata == 32'h0)
		else $error("outputs not quiet after reset");
	ptp_default_a: assert property (bus.re && bus.addr == rsf_pkg::ADDR_CTRL && $past(srst) |=> rdata[8])
		else $error("point to point mode not set after reset");
	unmapped_zero_a: assert property (bus.re && bus.addr == 8'h40 |=> rdata == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind rsf_framer rsf_framer_asserts rsf_framer_asserts_inst (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
	.line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n), .rts(rts));

// ==== tb/rsf_peer.sv ====
// peripheral device on the half-duplex line
`timescale 1ns/1ps
module rsf_peer (
	input wire logic clk,
	input wire logic line_out,
	input wire logic line_oe_n,
	output logic     line_in
);
	localparam int BIT = int'(rsf_pkg::DIV_RST);
	initial line_in = 1'b1;
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		while (!line_oe_n) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			line_in <= f[i];
			repeat (BIT) @(posedge clk);
		end
	endtask
	task automatic recv(output logic [7:0] b);
		int n;
		n = 0;
		while ((line_oe_n || line_out) && n < 20000) begin
			n++;
			@(posedge clk);
		end
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk);
			#1 b[i] = line_out;
		end
		repeat (BIT) @(posedge clk);
	endtask
endmodule

// ==== tb/rsf_framer_tb.sv ====
// self-checking bench for the serial framer
`timescale 1ns/1ps
module rsf_framer_tb;
	logic                  clk;
	logic                  srst;
	rsf_pkg::rsf_bus_req_t bus;
	logic [31:0]           rdata;
	logic                  line_in;
	logic                  line_out;
	logic                  line_oe_n;
	logic                  rts;
	logic [31:0]           d;
	logic [7:0]            b;
	int                    mismatches;
	int                    cmp_count;
	rsf_framer rsf_framer_inst (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .line_in(line_in),
		.line_out(line_out), .line_oe_n(line_oe_n), .rts(rts));
	rsf_peer rsf_peer_inst (.clk(clk), .line_out(line_out), .line_oe_n(line_oe_n), .line_in(line_in));
	always #50 clk = ~clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		bus.we <= 1'b1;
		bus.addr <= a;
		bus.wdata <= v;
		@(posedge clk);
		bus.we <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v);
		bus.re <= 1'b1;
		bus.addr <= a;
		@(posedge clk);
		bus.re <= 1'b0;
		#1 v = rdata;
		@(posedge clk);
	endtask
	task finish_test;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task test_reset;
		rd(rsf_pkg::ADDR_CTRL, d);
		chk(d, rsf_pkg::CTRL_RST);
		rd(rsf_pkg::ADDR_IDS, d);
		chk(d, 32'hffff_ffff);
		rd(rsf_pkg::ADDR_DIV, d);
		chk(d, 32'h0000_0057);
		rd(8'h40, d);
		chk(d, 32'h0);
	endtask
	task test_ascii_tx;
		wr(rsf_pkg::ADDR_TXDATA, 32'h41);
		wr(rsf_pkg::ADDR_TXDATA, 32'h5a);
		rsf_peer_inst.recv(b);
		chk({24'h0, b}, 32'h41);
		rsf_peer_inst.recv(b);
		chk({24'h0, b}, 32'h5a);
	endtask
	task test_ascii_rx;
		rsf_peer_inst.send(8'h55);
		rsf_peer_inst.send(8'h1b);
		repeat (8) @(posedge clk);
		rd(rsf_pkg::ADDR_RXDATA, d);
		chk(d, 32'h155);
		rd(rsf_pkg::ADDR_RXDATA, d);
		chk(d, 32'h11b);
		rd(rsf_pkg::ADDR_RXDATA, d);
		chk({31'h0, d[8]}, 32'h0);
	endtask
	task test_framed_rx;
		wr(rsf_pkg::ADDR_CTRL, 32'h131);
		wr(rsf_pkg::ADDR_IDS, 32'hff03_ff02);
		rsf_peer_inst.send(8'h7a);
		rsf_peer_inst.send(8'h02);
		rsf_peer_inst.send(8'h41);
		repeat (8) @(posedge clk);
		rd(rsf_pkg::ADDR_RXDATA, d);
		chk({31'h0, d[8]}, 32'h0);
		rsf_peer_inst.send(8'h03);
		repeat (8) @(posedge clk);
		rd(rsf_pkg::ADDR_RXDATA, d);
		chk(d, 32'h141);
	endtask
	task test_framed_tx;
		wr(rsf_pkg::ADDR_TXDATA, 32'h42);
		wr(rsf_pkg::ADDR_CMD, 32'h1);
		rsf_peer_inst.recv(b);
		chk({24'h0, b}, 32'h02);
		rsf_peer_inst.recv(b);
		chk({24'h0, b}, 32'h42);
		rsf_peer_inst.recv(b);
		chk({24'h0, b}, 32'h03);
	endtask
	task test_acked;
		wr(rsf_pkg::ADDR_CTRL, 32'h133);
		wr(rsf_pkg::ADDR_TMO, 32'h10);
		wr(rsf_pkg::ADDR_TXDATA, 32'h51);
		wr(rsf_pkg::ADDR_CMD, 32'h1);
		rsf_peer_inst.recv(b);
		chk({24'h0, b}, 32'h51);
		rd(rsf_pkg::ADDR_STATUS, d);
		chk({31'h0, d[rsf_pkg::ST_ACK_WAIT]}, 32'h1);
		rsf_peer_inst.send(8'h06);
		rd(rsf_pkg::ADDR_STATUS, d);
		chk(d & 32'h0000_01c3, 32'h0000_0082);
		rd(rsf_pkg::ADDR_RXDATA, d);
		chk(d, 32'h106);
		repeat (1500) @(posedge clk);
		wr(rsf_pkg::ADDR_CMD, 32'h1);
		repeat (1500) @(posedge clk);
		rd(rsf_pkg::ADDR_STATUS, d);
		chk(d & 32'h0000_01c6, 32'h0000_0104);
		wr(rsf_pkg::ADDR_STATUS, 32'h104);
		rd(rsf_pkg::ADDR_STATUS, d);
		chk(d & 32'h0000_0104, 32'h0);
	endtask
	task test_reset_mid;
		wr(rsf_pkg::ADDR_TXDATA, 32'h33);
		rd(rsf_pkg::ADDR_COUNT, d);
		chk(d, 32'h1);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(rsf_pkg::ADDR_CTRL, d);
		chk(d, rsf_pkg::CTRL_RST);
		rd(rsf_pkg::ADDR_COUNT, d);
		chk(d, 32'h0);
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		finish_test;
	end
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		bus = '0;
		mismatches = 0;
		cmp_count = 0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		test_reset;
		test_ascii_tx;
		test_ascii_rx;
		test_framed_rx;
		test_framed_tx;
		test_acked;
		test_reset_mid;
		finish_test;
	end
endmodule
